// [core/odcs_map.vh]
// odcs_map.vh - bit positions, reset values and timing counts of the driver control block
`ifndef ODCS_MAP_VH
`define ODCS_MAP_VH
// frame bit positions (drive_control_word / fault_status_word)
`define ODCS_BIT_SEL        0
`define ODCS_BIT_ENABLE     23
`define ODCS_BIT_CLEAR      22
`define ODCS_BIT_DUTY       21
`define ODCS_BIT_VRDIS      20
`define ODCS_BIT_MON_HI     19
`define ODCS_BIT_MON_LO     18
`define ODCS_BIT_OVV        22
`define ODCS_BIT_UNV        21
`define ODCS_BIT_TSD        20
`define ODCS_BIT_TW         19
`define ODCS_BIT_NRDY       18
// mask of the nine switch positions 17,15,14,6..1
`define ODCS_DRV_MASK       24'h02C07E
`define ODCS_WORD_RESET     24'h000000
// monitor select codes
`define ODCS_MON_F          2'h0
`define ODCS_MON_A          2'h2
`define ODCS_MON_D          2'h1
`define ODCS_MON_E          2'h3
// timing, clock 10 MHz
`define ODCS_CLK_HZ         10000000
`define ODCS_STARTUP_US     50
`define ODCS_STARTUP_CYC    ((`ODCS_STARTUP_US * `ODCS_CLK_HZ + 999999) / 1000000)
`define ODCS_RETRY_PERIOD_US 400
// cycles per microsecond first, so the product stays inside 32 bits
`define ODCS_RETRY_PERIOD_CYC (`ODCS_RETRY_PERIOD_US * (`ODCS_CLK_HZ / 1000000))
// on-time share of the retry period: 12 % and 25 %
`define ODCS_RETRY_ON12_CYC (`ODCS_RETRY_PERIOD_CYC * 12 / 100)
`define ODCS_RETRY_ON25_CYC (`ODCS_RETRY_PERIOD_CYC * 25 / 100)
`endif

// [core/odcs_retry.v]
// odcs_retry.v - overcurrent latch with optional timed auto-retry for one switch
`timescale 1ns/1ps
`include "odcs_map.vh"
module odcs_retry (
  // clock and reset
  input  wire CLK_I,
  input  wire RESET_I,
  // controls
  input  wire oc_i,        // overcurrent event from the switch
  input  wire clear_i,     // status clear pulse
  input  wire retry_en_i,  // auto-retry enabled for this switch
  input  wire duty_i,      // 0: 12 %, 1: 25 %
  input  wire standby_i,   // standby clears everything
  // results
  output reg  flag_o,      // sticky overcurrent flag
  output wire block_o      // driver held off
);
  reg [11:0] cnt_reg;  // retry off-time counter
  reg        off_reg;  // driver disabled by a trip
  // off times per duty, cut to the counter width where used
  localparam [31:0] OFF25_N = `ODCS_RETRY_PERIOD_CYC - `ODCS_RETRY_ON25_CYC;
  localparam [31:0] OFF12_N = `ODCS_RETRY_PERIOD_CYC - `ODCS_RETRY_ON12_CYC;
  wire [11:0] off_len;  // off time for the selected duty
  assign off_len = duty_i ? OFF25_N[11:0] : OFF12_N[11:0];
  assign block_o = off_reg;
  // trip, wait, re-enable
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      flag_o  <= 1'b0;
      off_reg <= 1'b0;
      cnt_reg <= 12'h000;
    end else if (standby_i) begin
      flag_o  <= 1'b0;
      off_reg <= 1'b0;
      cnt_reg <= 12'h000;
    end else if (oc_i) begin
      // set wins over clear
      flag_o  <= 1'b1; // RULE8
      off_reg <= 1'b1; // RULE8
      cnt_reg <= off_len;
    end else begin
      if (clear_i) begin
        flag_o <= 1'b0;
      end
      if (off_reg) begin
        if (retry_en_i) begin
          // timed re-enable gives pulsed current
          if (cnt_reg <= 12'h001) begin
            off_reg <= 1'b0; // RULE9
          end else begin
            cnt_reg <= cnt_reg - 12'h001;
          end
        end else if (clear_i) begin
          off_reg <= 1'b0; // RULE10
        end
      end
    end
  end
endmodule // odcs_retry

// [core/odcs_top.v]
// odcs_top.v - control and status logic of the multi-output load driver
// Notes on behaviour
// RULE1: thermal shutdown latches, all outputs off
// RULE2: temperature warning sticky until host clears
// RULE3: standby-to-active starts settle timer, outputs held
// RULE4: not-ready clears itself when timer ends
// RULE5: drive bit one switches that output on
// RULE6: gated outputs conduct only while pulse pin high
// RULE7: never both switches of one half bridge
// RULE8: overcurrent sets matching bit, disables driver
// RULE9: auto-retry re-enables after delay, duty bit 21
// RULE10: without retry, host clears before reactivation
// RULE11: bit zero is NOR of all fault bits
// RULE12: monitor select codes map to four outputs
// RULE13: supply faults auto-recover unless disabled
// RULE14: frame bit zero selects register pair
// RULE15: clear bit empties status at frame end
// RULE16: bits 19:18 drive monitor multiplexer
`timescale 1ns/1ps
`include "odcs_map.vh"
module odcs_top (
  // clock and reset
  input  wire        CLK_I,
  input  wire        RESET_I,
  // completed frame from the serial interface
  input  wire        FRAME_VALID_I,   // one-cycle pulse at chip-select rise, 24 bits exact
  input  wire [23:0] FRAME_DATA_I,    // received frame
  // other input register settings
  input  wire [23:0] GATE_EN_I,       // pulse gating enable per drive bit position
  input  wire [23:0] GATE_SEL_I,      // 0: pulse input 1, 1: pulse input 2, per position
  input  wire [23:0] RETRY_EN_I,      // overcurrent auto-retry enable per position
  input  wire        OTHER_FAULT_I,   // OR of bits 1..22 of the other status register
  // pulse gate pins
  input  wire        PULSE_GATE_INPUT_1_I,
  input  wire        PULSE_GATE_INPUT_2_I,
  // analog events
  input  wire [23:0] OVERCURRENT_I,   // overcurrent per drive bit position
  input  wire        THERMAL_SHUTDOWN_I,
  input  wire        TEMP_WARNING_I,
  input  wire        SUPPLY_OVER_I,
  input  wire        SUPPLY_UNDER_I,
  // outputs
  output reg  [23:0] DRIVE_O,         // switch on per drive bit position
  output reg  [1:0]  MONITOR_SEL_O,   // current monitor mux select
  output reg  [23:0] STATUS_O,        // fault_status_word for readout
  output wire        ACTIVE_O         // device in active mode
);
  // mode states, one-hot
  localparam [2:0] ST_STANDBY = 3'b001;
  localparam [2:0] ST_SETTLE  = 3'b010;
  localparam [2:0] ST_ACTIVE  = 3'b100;
  // settle reload, cut to the timer width where it is loaded
  localparam [31:0] SETTLE_LOAD_N = `ODCS_STARTUP_CYC - 1;

  reg  [2:0]  state_reg;      // mode
  reg  [2:0]  state_next;     // next mode
  reg  [23:0] ctrl_reg;       // drive_control_word
  reg  [12:0] settle_reg;     // settle countdown
  reg         tsd_reg;        // thermal shutdown flag
  reg         tw_reg;         // temperature warning flag
  reg         ovv_reg;        // supply over flag
  reg         unv_reg;        // supply under flag
  reg         supply_off_reg; // outputs held by supply fault
  wire        wr_this;        // frame for this pair
  wire        clr;            // status clear at frame end
  wire        standby;        // standby mode
  wire [23:0] oc_flag;        // overcurrent flags
  wire [23:0] oc_block;       // drivers held off by trip
  reg  [23:0] want;           // requested after gating
  reg  [23:0] stat_next;      // status word assembled

  // frame decode: write strobe and status clear
  assign wr_this = FRAME_VALID_I & ~FRAME_DATA_I[`ODCS_BIT_SEL]; // RULE14
  assign clr     = FRAME_VALID_I & FRAME_DATA_I[`ODCS_BIT_CLEAR]; // RULE15
  assign standby = state_reg[0];
  assign ACTIVE_O = state_reg[2];

  // drive register write
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl_reg <= `ODCS_WORD_RESET;
    end else if (wr_this) begin
      // a frame with bit 0 set belongs to the other pair
      ctrl_reg <= FRAME_DATA_I;
    end
  end

  // mode sequencing
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_STANDBY: if (ctrl_reg[`ODCS_BIT_ENABLE]) state_next = ST_SETTLE; // RULE3
      ST_SETTLE: begin
        // dropping enable mid-settle aborts back to standby
        if (!ctrl_reg[`ODCS_BIT_ENABLE]) state_next = ST_STANDBY;
        else if (settle_reg == 13'h0000) state_next = ST_ACTIVE; // RULE4
      end
      ST_ACTIVE: if (!ctrl_reg[`ODCS_BIT_ENABLE]) state_next = ST_STANDBY;
      default: state_next = ST_STANDBY;
    endcase
  end

  // mode register and settle timer
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_reg  <= ST_STANDBY;
      settle_reg <= 13'h0000;
    end else begin
      state_reg <= state_next;
      if (state_reg[0]) begin
        // standby keeps the timer primed, so settling starts full
        settle_reg <= SETTLE_LOAD_N[12:0]; // RULE3
      end else if (state_reg[1] && settle_reg != 13'h0000) begin
        // count down while settling, then hold at zero
        settle_reg <= settle_reg - 13'h0001;
      end
    end
  end

  // sticky thermal and supply flags, set wins over clear
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tsd_reg        <= 1'b0;
      tw_reg         <= 1'b0;
      ovv_reg        <= 1'b0;
      unv_reg        <= 1'b0;
      supply_off_reg <= 1'b0;
    end else if (standby) begin
      // standby clears every flag and the supply hold
      tsd_reg        <= 1'b0;
      tw_reg         <= 1'b0;
      ovv_reg        <= 1'b0;
      unv_reg        <= 1'b0;
      supply_off_reg <= 1'b0;
    end else begin
      // sticky latches: the event term wins over the clear
      tsd_reg <= THERMAL_SHUTDOWN_I | (tsd_reg & ~clr); // RULE1
      tw_reg  <= TEMP_WARNING_I | (tw_reg & ~clr);      // RULE2
      ovv_reg <= SUPPLY_OVER_I | (ovv_reg & ~clr);
      unv_reg <= SUPPLY_UNDER_I | (unv_reg & ~clr);
      // supply hold, released on recovery unless recovery is disabled
      if (SUPPLY_OVER_I | SUPPLY_UNDER_I) begin
        supply_off_reg <= 1'b1;
      end else if (!ctrl_reg[`ODCS_BIT_VRDIS] || clr) begin
        supply_off_reg <= 1'b0; // RULE13
      end
    end
  end

  // one overcurrent latch per switch position
  // duty select is shared, retry enable is per switch
  genvar g;
  generate
    for (g = 0; g < 24; g = g + 1) begin : g_oc
      if (((`ODCS_DRV_MASK >> g) & 1) != 0) begin : g_sw
        odcs_retry u_retry (
          .CLK_I      (CLK_I),
          .RESET_I    (RESET_I),
          .oc_i       (OVERCURRENT_I[g]),
          .clear_i    (clr),
          .retry_en_i (RETRY_EN_I[g]),
          .duty_i     (ctrl_reg[`ODCS_BIT_DUTY]),
          .standby_i  (standby),
          .flag_o     (oc_flag[g]),
          .block_o    (oc_block[g])
        );
      end else begin : g_none
        // unused positions read zero and never block
        assign oc_flag[g]  = 1'b0; // RULE8
        assign oc_block[g] = 1'b0;
      end
    end
  endgenerate

  // drive request, gating and half bridge interlock
  always @* begin : p_want
    integer i;
    i    = 0; // loop index, defined before any use
    want = ctrl_reg & `ODCS_DRV_MASK & ~oc_block; // RULE5 RULE8 RULE10
    // pulse gating per position, the selected pin must be high
    for (i = 0; i < 24; i = i + 1) begin
      if (GATE_EN_I[i] && !(GATE_SEL_I[i] ? PULSE_GATE_INPUT_2_I : PULSE_GATE_INPUT_1_I)) begin
        want[i] = 1'b0; // RULE6
      end
    end
    // half bridge pairs sit at bits 1/2, 3/4 and 5/6; a conflict turns both off
    for (i = 1; i < 6; i = i + 2) begin
      if (want[i] && want[i + 1]) begin
        want[i]     = 1'b0; // RULE7
        want[i + 1] = 1'b0; // RULE7
      end
    end
    // mode, thermal and supply holds override every request
    if (!state_reg[2] || tsd_reg || supply_off_reg) begin
      want = `ODCS_WORD_RESET; // RULE1 RULE3 RULE13
    end
  end

  // status word assembly
  always @* begin
    stat_next = oc_flag & `ODCS_DRV_MASK;
    // bit 23 always one so a dead link reads as invalid
    stat_next[`ODCS_BIT_ENABLE] = 1'b1;
    stat_next[`ODCS_BIT_OVV]    = ovv_reg;
    stat_next[`ODCS_BIT_UNV]    = unv_reg;
    stat_next[`ODCS_BIT_TSD]    = tsd_reg;
    stat_next[`ODCS_BIT_TW]     = tw_reg;
    stat_next[`ODCS_BIT_NRDY]   = state_reg[1]; // RULE3 RULE4
    // no-error bit last, after every fault bit is in place
    stat_next[0] = ~(|stat_next[22:1] | OTHER_FAULT_I); // RULE11
  end

  // registered outputs
  // data outputs come from flip-flops, one cycle behind the logic
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      DRIVE_O       <= `ODCS_WORD_RESET;
      MONITOR_SEL_O <= `ODCS_MON_F;
      STATUS_O      <= `ODCS_WORD_RESET;
    end else begin
      DRIVE_O       <= want;
      MONITOR_SEL_O <= {ctrl_reg[`ODCS_BIT_MON_HI], ctrl_reg[`ODCS_BIT_MON_LO]}; // RULE12 RULE16
      STATUS_O      <= stat_next;
    end
  end
endmodule // odcs_top

// [verification/odcs_chk_sva.sv]
// odcs_chk_sva.sv - port checker of the driver control block
`timescale 1ns/1ps
module odcs_chk (
  // clock, reset and scalar ports
  input wire        CLK_I, RESET_I, FRAME_VALID_I, OTHER_FAULT_I, ACTIVE_O,
  // word ports
  input wire [23:0] FRAME_DATA_I, RETRY_EN_I, DRIVE_O, STATUS_O,
  input wire [1:0]  MONITOR_SEL_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // active frame addressed to this register pair
  sequence s_wr;
    FRAME_VALID_I && !FRAME_DATA_I[0] && FRAME_DATA_I[23];
  endsequence
  a_mon_sel_follow: assert property (s_wr |-> ##2 MONITOR_SEL_O == $past(FRAME_DATA_I[19:18], 2))
    else $error("monitor select does not follow frame");
  a_tsd_all_off: assert property (STATUS_O[20] && $past(STATUS_O[20]) |-> DRIVE_O == 24'h000000)
    else $error("output on during thermal shutdown");
  a_tw_sticky: assert property ($fell(STATUS_O[19]) |-> $past(FRAME_VALID_I, 2) || $past(FRAME_VALID_I, 4))
    else $error("warning flag dropped without frame");
  a_idle_off: assert property (!ACTIVE_O |=> DRIVE_O == 24'h000000)
    else $error("output on while not active");
  a_nrdy_self: assert property ($fell(STATUS_O[18]) |-> ACTIVE_O || $past(FRAME_VALID_I, 3))
    else $error("not ready cleared without activation");
  a_drive_mask: assert property ((DRIVE_O & ~24'h02C07E) == 24'h000000)
    else $error("unused drive position high");
  a_no_shoot: assert property ((DRIVE_O[6:1] & (DRIVE_O[6:1] >> 1) & 6'h15) == 6'h00)
    else $error("both switches of a bridge on");
  a_oc_off: assert property ((STATUS_O & $past(STATUS_O) & ~RETRY_EN_I & DRIVE_O & 24'h02C07E) == 24'h000000)
    else $error("tripped driver still on");
  a_nor_ok: assert property (!$past(RESET_I) |-> STATUS_O[0] == !((|STATUS_O[22:1]) || $past(OTHER_FAULT_I)))
    else $error("no error bit wrong");
  a_fixed_bits: assert property (!$past(RESET_I) |-> STATUS_O[23] && !STATUS_O[16] && STATUS_O[13:7] == 7'h00)
    else $error("fixed status bits wrong");
endmodule // odcs_chk
bind odcs_top odcs_chk chk_u (.CLK_I, .RESET_I, .FRAME_VALID_I, .OTHER_FAULT_I, .ACTIVE_O, .FRAME_DATA_I,
  .RETRY_EN_I, .DRIVE_O, .STATUS_O, .MONITOR_SEL_O);

// [verification/odcs_host.sv]
// odcs_host.sv - microcontroller model handing complete frames to the block
`timescale 1ns/1ps
module odcs_host (
  // clock in, frame out
  input  wire        clk_i,
  output reg         valid_o,
  output reg  [23:0] data_o
);
  initial begin
    valid_o = 1'b0;
    data_o  = 24'h000000;
  end
  // one exact 24-bit frame, bit 0 picks the register pair
  task send(input [23:0] w);
    begin
      @(posedge clk_i);
      valid_o <= 1'b1;
      data_o  <= w;
      @(posedge clk_i);
      valid_o <= 1'b0;
      data_o  <= ~w; // no stale data after the frame
    end
  endtask
endmodule // odcs_host

// [verification/output_driver_control_status_tb.sv]
// output_driver_control_status_tb.sv - self-checking bench of the driver control block
`timescale 1ns/1ps
`include "odcs_map.vh"
module output_driver_control_status_tb;
  reg         clk_i = 1'b0, reset_i = 1'b1, pg2 = 1'b0, thermal_shutdown_flag = 1'b0, tw = 1'b0, unv = 1'b0;
  reg         pg1 = 1'b0, sov = 1'b0, other = 1'b0;
  reg  [23:0] gate_en = 24'h000000, gate_sel = 24'h000000, oc = 24'h000000;
  reg  [23:0] retry_en = 24'h000000;
  wire        fv, active;
  wire [23:0] fd, drive, status;
  wire [1:0]  mon;
  integer     fail_count = 0, checks = 0, n, d, e;
  odcs_host host_u (.clk_i(clk_i), .valid_o(fv), .data_o(fd));
  odcs_top dut_u (.CLK_I(clk_i), .RESET_I(reset_i), .FRAME_VALID_I(fv), .FRAME_DATA_I(fd),
    .GATE_EN_I(gate_en), .GATE_SEL_I(gate_sel), .RETRY_EN_I(retry_en), .OTHER_FAULT_I(other),
    .PULSE_GATE_INPUT_1_I(pg1), .PULSE_GATE_INPUT_2_I(pg2), .OVERCURRENT_I(oc),
    .THERMAL_SHUTDOWN_I(thermal_shutdown_flag), .TEMP_WARNING_I(tw), .SUPPLY_OVER_I(sov), .SUPPLY_UNDER_I(unv),
    .DRIVE_O(drive), .MONITOR_SEL_O(mon), .STATUS_O(status), .ACTIVE_O(active));
  // 10 MHz clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task wt(input integer c);
    begin
      repeat (c) @(posedge clk_i);
      #1;
    end
  endtask
  // compare seen against expected
  task chk(input [23:0] s, input [23:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // settle timer after standby, then drive bit 2
  task t_startup;
    begin
      host_u.send(24'h800004);
      wt(10);
      chk(status[18], 1'b1);
      chk(drive, 24'h000000);
      n = 10;
      while (active !== 1'b1 && n < 1000) begin
        wt(1);
        n = n + 1;
      end
      chk(n >= 500 && n <= 503, 1'b1);
      wt(3);
      chk(drive, 24'h000004);
      chk(status, 24'h800001);
      $display("startup test done");
    end
  endtask
  // ignored bits, bridge conflict and monitor codes
  task t_map;
    begin
      host_u.send(24'h83FFFE);
      wt(4);
      chk(drive, 24'h02C000);
      for (n = 0; n < 4; n = n + 1) begin
        host_u.send(24'h800000 | (n << 18));
        wt(4);
        chk(mon, n);
      end
      host_u.send(24'h820001);
      wt(4);
      chk(mon, 2'h3);
      $display("map test done");
    end
  endtask
  // pulse gating on input 2, then on input 1
  task t_gate;
    begin
      host_u.send(24'h820000);
      gate_en <= 24'h020000;
      gate_sel <= 24'h020000;
      wt(4);
      chk(drive, 24'h000000);
      @(posedge clk_i) pg2 <= 1'b1;
      wt(3);
      chk(drive, 24'h020000);
      @(posedge clk_i) gate_sel <= 24'h000000;
      wt(3);
      chk(drive, 24'h000000);
      @(posedge clk_i) pg1 <= 1'b1;
      wt(3);
      chk(drive, 24'h020000);
      @(posedge clk_i) gate_en <= 24'h000000;
      $display("gate test done");
    end
  endtask
  // overcurrent, thermal and supply faults
  task t_faults;
    begin
      @(posedge clk_i) oc <= 24'h020000;
      @(posedge clk_i) oc <= 24'h000000;
      wt(25);
      chk(status, 24'h820000);
      chk(drive, 24'h000000);
      host_u.send(24'hC20000);
      wt(4);
      chk(status, 24'h800001);
      chk(drive, 24'h020000);
      @(posedge clk_i) {thermal_shutdown_flag, tw} <= 2'h3;
      @(posedge clk_i) {thermal_shutdown_flag, tw} <= 2'h0;
      wt(30);
      chk(status, 24'h980000);
      chk(drive, 24'h000000);
      host_u.send(24'hC20000);
      wt(4);
      chk(drive, 24'h020000);
      @(posedge clk_i) unv <= 1'b1;
      wt(5);
      chk(drive, 24'h000000);
      @(posedge clk_i) unv <= 1'b0;
      wt(5);
      chk(drive, 24'h020000);
      $display("fault test done");
    end
  endtask
  // overcurrent auto-retry at both duty settings
  task t_retry;
    begin
      for (d = 0; d < 2; d = d + 1) begin
        host_u.send(24'hC20000 | (d << 21));
        @(posedge clk_i);
        retry_en <= 24'h020000;
        oc <= 24'h020000;
        @(posedge clk_i) oc <= 24'h000000;
        wt(2);
        n = 2;
        while (drive[17] !== 1'b1 && n < 5000) begin
          wt(1);
          n = n + 1;
        end
        e = d ? (`ODCS_RETRY_PERIOD_CYC - `ODCS_RETRY_ON25_CYC) : (`ODCS_RETRY_PERIOD_CYC - `ODCS_RETRY_ON12_CYC);
        chk(n, e + 1);
        chk(status, 24'h820000);
        host_u.send(24'hC20000);
        wt(4);
        chk(status, 24'h800001);
        chk(drive, 24'h020000);
      end
      @(posedge clk_i) retry_en <= 24'h000000;
      $display("retry test done");
    end
  endtask
  // supply hold with recovery disabled, other register fault
  task t_supply;
    begin
      host_u.send(24'h920000);
      @(posedge clk_i) sov <= 1'b1;
      @(posedge clk_i) sov <= 1'b0;
      wt(5);
      chk(status, 24'hC00000);
      chk(drive, 24'h000000);
      host_u.send(24'hC20000);
      wt(4);
      chk(drive, 24'h020000);
      chk(status, 24'h800001);
      @(posedge clk_i) other <= 1'b1;
      wt(3);
      chk(status, 24'h800000);
      @(posedge clk_i) other <= 1'b0;
      $display("supply test done");
    end
  endtask
  // watchdog
  initial begin
    #(20000 * 100);
    fail_count = fail_count + 1;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_startup;
    t_map;
    t_gate;
    t_faults;
    t_retry;
    t_supply;
    finish_test;
  end
endmodule // output_driver_control_status_tb
